// File: common/dma_chan_pkg.sv
// Purpose: Constants for the single-channel transfer setup block.
// Assumes: APB byte addresses, one 32-bit word per register.
// Notes: Field positions follow the channel setup word layout.
package dma_chan_pkg;
   // Register byte offsets
   localparam logic [7:0] OFF_FLAGS = 8'h00;
   localparam logic [7:0] OFF_CLEAR = 8'h04;
   localparam logic [7:0] OFF_SETUP = 8'h08;
   localparam logic [7:0] OFF_REMAIN = 8'h0C;
   localparam logic [7:0] OFF_PPTR = 8'h10;
   localparam logic [7:0] OFF_MPTR = 8'h14;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;

   // Channel setup fields
   localparam int B_ON = 0;
   localparam int B_DONEIE = 1;
   localparam int B_MIDIE = 2;
   localparam int B_FAULTIE = 3;
   localparam int B_DIR = 4;
   localparam int B_WRAP = 5;
   localparam int B_PSTEP = 6;
   localparam int B_MSTEP = 7;
   localparam int PW_LO = 8;
   localparam int MW_LO = 10;
   localparam int ARB_LO = 12;
   localparam int B_M2M = 14;
   localparam int LOCK_LO = 4;
   localparam int SETUP_HI = 14;

   // Event flag and clear bank fields
   localparam int F_ANY = 0;
   localparam int F_DONE = 1;
   localparam int F_MID = 2;
   localparam int F_FAULT = 3;
   localparam int FLAG_W = 4;

   localparam int CNT_W = 16;
   localparam int LAST_IDX = 5;

   // Beat size codes; the fourth code is reserved
   localparam logic [1:0] SZ_8 = 2'h0;
   localparam logic [1:0] SZ_16 = 2'h1;
   localparam logic [1:0] SZ_32 = 2'h2;
   localparam logic [31:0] STEP_1 = 32'h0000_0001;
   localparam logic [31:0] STEP_2 = 32'h0000_0002;
   localparam logic [31:0] STEP_4 = 32'h0000_0004;

   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_BUSY = 1'b1
   } xfer_state_t;
endpackage

// File: design/dma_chan_regs.sv
// Purpose: Setup registers and transfer sequencing of one channel.
// Assumes: APB slave, one clock, the bus master acknowledges beats.
// Notes: Each beat is requested on xferReq and ends on xferAck or xferErr.
// Functional notes
// - Memory-to-memory bit fourteen, locked while on
// - Two-bit arbitration level, locked while on
// - Direction, wrap and step bits locked while on
// - Widths: 8, 16, 32 bit; eleven reserved
// - Memory step bit: fixed or increasing address
// - Peripheral step bit: fixed or increasing address
// - Direction bit selects source and destination
// - Wraparound reloads counter after completion
// - Fault interrupt gated by its enable
// - Midpoint interrupt gated by its enable
// - Done interrupt gated by its enable
// - Counter read-only when on, counts down
// - No transfer while counter is zero
// - Counter and pointers locked while on
// - Half-word beats drop pointer bit zero
// - Word beats drop two pointer bits
// - Hardware sets flags, write one clears
// - Channel interrupt when enabled flag set
//
// Design decision made here: the APB register port.
`timescale 1ns/10ps
`default_nettype none

module dma_chan_regs
   import dma_chan_pkg::*;
(
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic perReq,
   input wire logic xferAck,
   input wire logic xferErr,
   output logic xferReq,
   output logic [31:0] srcAddr,
   output logic [31:0] dstAddr,
   output logic [1:0] srcSize,
   output logic [1:0] dstSize,
   output logic [1:0] arbLevel,
   output logic chanIrq
);

   // Beat size decode; reserved code falls back to byte beats
   function automatic logic [31:0] stepOf(input logic [1:0] sz);
      logic [31:0] s;
      s = STEP_1;
      if (sz == SZ_16) begin
         s = STEP_2;
      end else if (sz == SZ_32) begin
         s = STEP_4;
      end
      return s;
   endfunction

   function automatic logic [31:0] alignOf(input logic [31:0] a,
                                           input logic [1:0] sz);
      return a & ~(stepOf(sz) - STEP_1);
   endfunction

   logic rstMeta_q;
   logic rstN;
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic [SETUP_HI:0] setup_q;
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] reload_q;
   logic [31:0] perBase_q;
   logic [31:0] memBase_q;
   logic [31:0] perCur_q;
   logic [31:0] memCur_q;
   logic [FLAG_W-1:0] flags_q;
   logic [FLAG_W-1:0] flags_d;
   logic chanIrq_q;
   logic xferReq_q;
   logic [31:0] srcAddr_q;
   logic [31:0] dstAddr_q;
   logic [1:0] srcSize_q;
   logic [1:0] dstSize_q;
   xfer_state_t state_q;

   logic acc;
   logic wr;
   logic mapped;
   logic on;
   logic [1:0] perSz;
   logic [1:0] memSz;
   logic beatEnd;
   logic faultEv;
   logic [CNT_W-1:0] cntNext;
   logic lastBeat;
   logic reloadNow;
   logic midEv;
   logic canStart;
   logic [FLAG_W-1:0] setMask;
   logic [FLAG_W-1:0] clrMask;
   logic [31:0] rdMux;

   // Reset release through two flops
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rstMeta_q <= 1'b0;
         rstN <= 1'b0;
      end else begin
         rstMeta_q <= 1'b1;
         rstN <= rstMeta_q;
      end
   end

   assign on = setup_q[B_ON];
   assign perSz = setup_q[PW_LO+1:PW_LO];
   assign memSz = setup_q[MW_LO+1:MW_LO];
   assign acc = psel & penable;
   // One wait state keeps read data registered
   assign wr = acc & pready_q & pwrite;
   assign mapped = (paddr[1:0] == 2'h0) && (paddr[7:2] <= 6'(LAST_IDX));

   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q <= acc & ~pready_q;
         pslverr_q <= acc & ~pready_q & ~mapped;
      end
   end

   always_comb begin
      rdMux = RST_WORD;
      unique case (paddr)
         OFF_FLAGS: rdMux[FLAG_W-1:0] = flags_q;
         OFF_SETUP: rdMux[SETUP_HI:0] = setup_q;
         OFF_REMAIN: rdMux[CNT_W-1:0] = cnt_q;
         OFF_PPTR: rdMux = perBase_q;
         OFF_MPTR: rdMux = memBase_q;
         default: rdMux = RST_WORD;
      endcase
   end

   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         prdata_q <= RST_WORD;
      end else if (acc & ~pready_q & ~pwrite) begin
         prdata_q <= rdMux;
      end
   end

   // Beat bookkeeping
   assign beatEnd = (state_q == ST_BUSY) & xferAck & ~xferErr;
   assign faultEv = (state_q == ST_BUSY) & xferErr;
   assign cntNext = cnt_q - CNT_W'(1);
   assign lastBeat = beatEnd & (cntNext == '0);
   assign reloadNow = lastBeat & setup_q[B_WRAP];
   assign midEv = beatEnd & (cntNext == (reload_q >> 1));
   assign canStart = on & (cnt_q != '0) & (setup_q[B_M2M] | perReq);

   // Setup word; enables stay writable, mode fields lock
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         setup_q <= '0;
      end else if (wr && paddr == OFF_SETUP) begin
         setup_q[B_FAULTIE:B_ON] <= pwdata[B_FAULTIE:B_ON];
         if (!on) begin
            setup_q[SETUP_HI:LOCK_LO] <= pwdata[SETUP_HI:LOCK_LO];
         end
      end else if (faultEv) begin
         // A failed beat leaves the channel off for software to inspect
         setup_q[B_ON] <= 1'b0;
      end
   end

   assign arbLevel = setup_q[ARB_LO+1:ARB_LO];

   // Remaining counter
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         cnt_q <= '0;
         reload_q <= '0;
      end else if (wr && paddr == OFF_REMAIN && !on) begin
         cnt_q <= pwdata[CNT_W-1:0];
         reload_q <= pwdata[CNT_W-1:0];
      end else if (beatEnd) begin
         cnt_q <= reloadNow ? reload_q : cntNext;
      end
   end

   // Base pointers
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         perBase_q <= RST_WORD;
         memBase_q <= RST_WORD;
      end else if (wr && !on) begin
         if (paddr == OFF_PPTR) begin
            perBase_q <= pwdata;
         end
         if (paddr == OFF_MPTR) begin
            memBase_q <= pwdata;
         end
      end
   end

   // Working pointers follow the bases while the channel is off
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         perCur_q <= RST_WORD;
         memCur_q <= RST_WORD;
      end else if (!on || reloadNow) begin
         perCur_q <= perBase_q;
         memCur_q <= memBase_q;
      end else if (beatEnd) begin
         if (setup_q[B_PSTEP]) begin
            perCur_q <= perCur_q + stepOf(perSz);
         end
         if (setup_q[B_MSTEP]) begin
            memCur_q <= memCur_q + stepOf(memSz);
         end
      end
   end

   // Beat request sequencer
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         state_q <= ST_IDLE;
         xferReq_q <= 1'b0;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               if (canStart) begin
                  state_q <= ST_BUSY;
                  xferReq_q <= 1'b1;
               end
            end
            ST_BUSY: begin
               if (xferAck || xferErr || !on) begin
                  state_q <= ST_IDLE;
                  xferReq_q <= 1'b0;
               end
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         srcAddr_q <= RST_WORD;
         dstAddr_q <= RST_WORD;
         srcSize_q <= SZ_8;
         dstSize_q <= SZ_8;
      end else if (state_q == ST_IDLE && canStart) begin
         if (setup_q[B_DIR]) begin
            srcAddr_q <= alignOf(memCur_q, memSz);
            dstAddr_q <= alignOf(perCur_q, perSz);
            srcSize_q <= memSz;
            dstSize_q <= perSz;
         end else begin
            srcAddr_q <= alignOf(perCur_q, perSz);
            dstAddr_q <= alignOf(memCur_q, memSz);
            srcSize_q <= perSz;
            dstSize_q <= memSz;
         end
      end
   end

   // Event flags; a new event beats a clear in the same cycle
   always_comb begin
      setMask = '0;
      setMask[F_FAULT] = faultEv;
      setMask[F_MID] = midEv;
      setMask[F_DONE] = lastBeat;
      setMask[F_ANY] = faultEv | midEv | lastBeat;
      clrMask = '0;
      if (wr && paddr == OFF_CLEAR) begin
         clrMask = pwdata[FLAG_W-1:0];
         if (pwdata[F_ANY]) begin
            clrMask = '1;
         end
      end
      flags_d = (flags_q & ~clrMask) | setMask;
   end

   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         flags_q <= '0;
         chanIrq_q <= 1'b0;
      end else begin
         flags_q <= flags_d;
         chanIrq_q <= (flags_q[F_FAULT] & setup_q[B_FAULTIE])
                    | (flags_q[F_MID] & setup_q[B_MIDIE])
                    | (flags_q[F_DONE] & setup_q[B_DONEIE]);
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign xferReq = xferReq_q;
   assign srcAddr = srcAddr_q;
   assign dstAddr = dstAddr_q;
   assign srcSize = srcSize_q;
   assign dstSize = dstSize_q;
   assign chanIrq = chanIrq_q;

   default clocking dc @(posedge core_clk);
   endclocking
   default disable iff (!rstN);

   m2m_lock_a: assert property (
      on && wr && paddr == OFF_SETUP |=> $stable(setup_q[B_M2M]))
      else $error("mode bit changed while on");

   arb_lock_a: assert property (
      on && wr && paddr == OFF_SETUP |=> $stable(arbLevel))
      else $error("arbitration level changed while on");

   modes_lock_a: assert property (
      on && wr && paddr == OFF_SETUP
      |=> $stable(setup_q[B_MSTEP:B_DIR]))
      else $error("mode bits changed while on");

   size_code_a: assert property (
      $rose(xferReq) && srcSize == SZ_32 |-> srcAddr[1:0] == 2'h0)
      else $error("word beat not aligned");

   mem_fixed_a: assert property (
      beatEnd && on && !setup_q[B_MSTEP] && !reloadNow |=> $stable(memCur_q))
      else $error("fixed memory pointer moved");

   per_step_a: assert property (
      beatEnd && setup_q[B_PSTEP] && !reloadNow && on
      |=> perCur_q == $past(perCur_q) + stepOf($past(perSz)))
      else $error("peripheral pointer step wrong");

   dir_route_a: assert property (
      state_q == ST_IDLE && canStart && !setup_q[B_DIR]
      |=> srcAddr == alignOf($past(perCur_q), $past(perSz)))
      else $error("source not peripheral");

   wrap_reload_a: assert property (
      reloadNow |=> cnt_q == reload_q)
      else $error("wrap reload missing");

   irq_gate_a: assert property (
      flags_q[F_DONE] && setup_q[B_DONEIE] |=> chanIrq)
      else $error("enabled flag gave no interrupt");

   irq_block_a: assert property (
      !(flags_q[F_MID] & setup_q[B_MIDIE])
      && !(flags_q[F_DONE] & setup_q[B_DONEIE])
      && !setup_q[B_FAULTIE] |=> !chanIrq)
      else $error("masked event raised interrupt");

   count_down_a: assert property (
      beatEnd && on && !reloadNow |=> cnt_q == $past(cnt_q) - CNT_W'(1))
      else $error("counter did not step down");

   zero_idle_a: assert property (
      cnt_q == '0 && state_q == ST_IDLE |=> !xferReq)
      else $error("beat issued with zero count");

   ptr_lock_a: assert property (
      on && wr |=> $stable(perBase_q) && $stable(memBase_q))
      else $error("pointer written while on");

   half_align_a: assert property (
      $rose(xferReq) && dstSize == SZ_16 |-> dstAddr[0] == 1'b0)
      else $error("half-word beat not aligned");

   set_wins_a: assert property (
      lastBeat |=> flags_q[F_DONE] && flags_q[F_ANY])
      else $error("done event lost");

   wrap_cov: cover property (reloadNow);
   mid_cov: cover property (midEv ##[1:50] lastBeat);
   fault_cov: cover property (faultEv ##1 !on);
   irq_cov: cover property ($rose(chanIrq));

endmodule // dma_chan_regs

`default_nettype wire

// File: testbench/beat_partner.sv
// Purpose: Bus-master side of the beat port that answers each requested beat.
// Assumes: One clock; one answer per beat, pulsed for one cycle.
// Notes: waitCycles sets the answer delay; failNext answers with an error.
`timescale 1ns/10ps
`default_nettype none
module beat_partner (
   input wire logic core_clk,
   input wire logic reset_n,
   input wire logic xferReq,
   input wire logic [3:0] waitCycles,
   input wire logic failNext,
   output logic xferAck,
   output logic xferErr
);
   logic [3:0] waitCnt_q;

   // No second answer while the request is still falling after the first
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         xferAck <= 1'h0;
         xferErr <= 1'h0;
         waitCnt_q <= 4'h0;
      end else begin
         xferAck <= 1'h0;
         xferErr <= 1'h0;
         if (xferReq && !xferAck && !xferErr) begin
            if (waitCnt_q >= waitCycles) begin
               xferAck <= !failNext;
               xferErr <= failNext;
               waitCnt_q <= 4'h0;
            end else begin
               waitCnt_q <= waitCnt_q + 4'h1;
            end
         end
      end
   end
endmodule // beat_partner
`default_nettype wire

// File: testbench/test_dma_chan_regs.sv
// Purpose: Self-checking bench for channel setup registers and beat sequencing.
// Assumes: APB slave answers with one wait cycle; partner acknowledges beats.
// Notes: Register table first, then transfer, lock, wrap, fault and reset cases.
`timescale 1ns/10ps
`default_nettype none
module test_dma_chan_regs
   import dma_chan_pkg::*;
;
   typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] exp; logic err;} row_t;
   logic core_clk = 1'h0, reset_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic perReq = 1'h0, failNext = 1'h0, er;
   logic [3:0] waitSel = 4'h0;
   logic [7:0] paddr = 8'h0;
   logic [31:0] pwdata = 32'h0, prdata, srcAddr, dstAddr, rd;
   logic pready, pslverr, xferAck, xferErr, xferReq, chanIrq;
   logic [1:0] srcSize, dstSize, arbLevel;
   int errCount = 0, testsRun = 0;
   row_t rows [16] = '{
      '{1'h0, OFF_SETUP, 32'h0, 32'h0, 1'h0}, '{1'h0, OFF_REMAIN, 32'h0, 32'h0, 1'h0},
      '{1'h0, OFF_PPTR, 32'h0, 32'h0, 1'h0}, '{1'h0, OFF_MPTR, 32'h0, 32'h0, 1'h0},
      '{1'h0, OFF_FLAGS, 32'h0, 32'h0, 1'h0}, '{1'h1, OFF_SETUP, 32'h0000_7FFE, 32'h0, 1'h0},
      '{1'h0, OFF_SETUP, 32'h0, 32'h0000_7FFE, 1'h0}, '{1'h1, OFF_REMAIN, 32'hFFFF_0004, 32'h0, 1'h0},
      '{1'h0, OFF_REMAIN, 32'h0, 32'h0000_0004, 1'h0}, '{1'h1, OFF_PPTR, 32'h1234_5677, 32'h0, 1'h0},
      '{1'h0, OFF_PPTR, 32'h0, 32'h1234_5677, 1'h0}, '{1'h1, OFF_FLAGS, 32'h0000_000F, 32'h0, 1'h0},
      '{1'h0, OFF_FLAGS, 32'h0, 32'h0, 1'h0}, '{1'h0, OFF_CLEAR, 32'h0, 32'h0, 1'h0},
      '{1'h0, 8'h18, 32'h0, 32'h0, 1'h1}, '{1'h0, 8'h0A, 32'h0, 32'h0, 1'h1}};

   always #5 core_clk = ~core_clk;

   dma_chan_regs dut (.core_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .perReq, .xferAck, .xferErr, .xferReq, .srcAddr, .dstAddr, .srcSize, .dstSize,
      .arbLevel, .chanIrq);
   beat_partner partner (.core_clk, .reset_n, .xferReq, .waitCycles(waitSel), .failNext, .xferAck,
      .xferErr);

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", testsRun, errCount);
      if (errCount == 0 && testsRun > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      testsRun++;
      if (got !== exp) begin
         errCount++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // Entered just after a rising edge; an idle cycle follows every transfer
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'h1;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'h1 && n < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      chk({31'h0, pready}, 32'h1, "ready");
      @(posedge core_clk);
   endtask

   task automatic apbw(input logic [7:0] a, input logic [31:0] d);
      apb(1'h1, a, d);
   endtask

   task automatic apbr(input logic [7:0] a, input logic [31:0] exp);
      apb(1'h0, a, 32'h0);
      chk(rd, exp, "register read");
   endtask

   task automatic beat(input logic [31:0] s, input logic [31:0] d, input logic [3:0] sz);
      int n;
      n = 0;
      while (xferReq !== 1'h1 && n < 60) begin
         @(posedge core_clk);
         n++;
      end
      chk({31'h0, xferReq}, 32'h1, "request");
      chk(srcAddr, s, "source address");
      chk(dstAddr, d, "destination address");
      chk({28'h0, srcSize, dstSize}, {28'h0, sz}, "beat sizes");
      while ((xferAck | xferErr) !== 1'h1 && n < 60) begin
         @(posedge core_clk);
         n++;
      end
      chk({31'h0, (xferAck | xferErr)}, 32'h1, "beat answer");
      @(posedge core_clk);
   endtask

   initial begin
      repeat (8) @(posedge core_clk);
      reset_n <= 1'h1;
      repeat (3) @(posedge core_clk);
      foreach (rows[i]) begin
         apb(rows[i].w, rows[i].a, rows[i].d);
         if (!rows[i].w) begin
            chk(rd, rows[i].exp, "table read");
            chk({31'h0, er}, {31'h0, rows[i].err}, "slave error");
         end
      end
      chk({30'h0, arbLevel}, 32'h3, "level port");
      $display("register table done");
      waitSel <= 4'h3;
      perReq <= 1'h1;
      apbw(OFF_PPTR, 32'h0000_1003);
      apbw(OFF_MPTR, 32'h0000_2007);
      apbw(OFF_REMAIN, 32'h0000_0004);
      apbw(OFF_SETUP, 32'h0000_09C7);
      for (int k = 0; k < 4; k++)
         beat(32'h0000_1002 + 32'(2 * k), 32'h0000_2004 + 32'(4 * k), 4'h6);
      repeat (10) @(posedge core_clk);
      chk({31'h0, xferReq}, 32'h0, "idle at zero count");
      apbr(OFF_FLAGS, 32'h0000_0007);
      apbr(OFF_REMAIN, 32'h0);
      chk({31'h0, chanIrq}, 32'h1, "interrupt");
      apbw(OFF_SETUP, 32'h0000_0001);
      apbw(OFF_REMAIN, 32'h0000_0009);
      apbw(OFF_PPTR, 32'hFFFF_FFFF);
      apbr(OFF_SETUP, 32'h0000_09C1);
      apbr(OFF_REMAIN, 32'h0);
      apbr(OFF_PPTR, 32'h0000_1003);
      chk({31'h0, chanIrq}, 32'h0, "gated interrupt");
      apbw(OFF_CLEAR, 32'h0000_0004);
      apbr(OFF_FLAGS, 32'h0000_0003);
      apbw(OFF_CLEAR, 32'h0000_0001);
      apbr(OFF_FLAGS, 32'h0);
      apbw(OFF_SETUP, 32'h0);
      $display("transfer case done");
      // Memory to memory runs without any peripheral request
      waitSel <= 4'h0;
      perReq <= 1'h0;
      apbw(OFF_REMAIN, 32'h0000_0002);
      apbw(OFF_SETUP, 32'h0000_6031);
      chk({30'h0, arbLevel}, 32'h2, "level port");
      repeat (3) beat(32'h0000_2007, 32'h0000_1003, 4'h0);
      failNext <= 1'h1;
      beat(32'h0000_2007, 32'h0000_1003, 4'h0);
      failNext <= 1'h0;
      apbr(OFF_FLAGS, 32'h0000_000F);
      apbr(OFF_SETUP, 32'h0000_6030);
      chk({31'h0, chanIrq}, 32'h0, "fault masked");
      apbw(OFF_SETUP, 32'h0000_6038);
      repeat (2) @(posedge core_clk);
      chk({31'h0, chanIrq}, 32'h1, "fault raised");
      apbw(OFF_CLEAR, 32'h0000_0001);
      repeat (2) @(posedge core_clk);
      chk({31'h0, chanIrq}, 32'h0, "all cleared");
      $display("wrap and fault case done");
      // Reset lands just as a beat request is raised
      apbw(OFF_SETUP, 32'h0000_6039);
      reset_n <= 1'h0;
      @(posedge core_clk);
      chk({30'h0, xferReq, chanIrq}, 32'h0, "outputs in reset");
      @(posedge core_clk);
      reset_n <= 1'h1;
      repeat (3) @(posedge core_clk);
      apbr(OFF_SETUP, 32'h0);
      apbr(OFF_REMAIN, 32'h0);
      apbr(OFF_MPTR, 32'h0);
      chk({30'h0, xferReq, chanIrq}, 32'h0, "idle after reset");
      $display("reset case done");
      conclude();
   end

   // The whole sequence needs well under 2000 cycles
   initial begin
      #100us;
      errCount++;
      conclude();
   end
endmodule // test_dma_chan_regs
`default_nettype wire
